// File: sscc_params.svh
// Offsets, control word fields, reset values and timing counts
`ifndef SSCC_PARAMS_SVH
`define SSCC_PARAMS_SVH

// Control word layout
`define SSCC_CW_RESET        32'h0000_03FF
`define SSCC_CW_DAC_MSB      9
`define SSCC_CW_BUF_PD       12
`define SSCC_CW_REF_EN       13
`define SSCC_CW_CLK_SEL      11
`define SSCC_CW_REF_RANGE    18
`define SSCC_CW_POLARITY     20
`define SSCC_CW_SEQ          23
`define SSCC_CW_SPAN         26

// Host APB register offsets
`define SSCC_OFS_CTRL        12'h000
`define SSCC_OFS_START       12'h004
`define SSCC_OFS_CW          12'h008
`define SSCC_OFS_STATUS      12'h00C

// Timing
`define SSCC_SYS_PERIOD_NS   4
`define SSCC_EXTERNAL_CONVERSION_CLOCK_MIN_PER_NS 50
`define SSCC_EXTERNAL_CONVERSION_CLOCK_HALF_CYC   ((`SSCC_EXTERNAL_CONVERSION_CLOCK_MIN_PER_NS / 2 + \
  `SSCC_SYS_PERIOD_NS - 1) / `SSCC_SYS_PERIOD_NS)
`define SSCC_INT_HALF_CYC    3
`define SSCC_CONV_CYC_X2     37

`endif

// File: sscc_pkg.sv
// Types used by the device end of the conversion control link
package sscc_pkg;

  typedef enum logic [1:0] {
    PAIR_IDLE = 2'b00,
    PAIR_WAIT = 2'b01,
    PAIR_CONV = 2'b10
  } sscc_pair_state_t;

endpackage

// File: sscc_if.sv
// Link between the converter device and its host controller
`timescale 1ns/10ps
interface sscc_if;
  logic [2:0]  start;
  logic        cfg_src;
  logic        range_pin;
  logic        ext_clk;
  logic        busy_int;
  logic        cw_wr;
  logic [31:0] cw_data;

  modport dev (
    input  start,
    input  cfg_src,
    input  range_pin,
    input  ext_clk,
    input  cw_wr,
    input  cw_data,
    output busy_int
  );

  modport host (
    output start,
    output cfg_src,
    output range_pin,
    output ext_clk,
    output cw_wr,
    output cw_data,
    input  busy_int
  );
endinterface

// File: sscc_pair.sv
// Conversion sequencer for one channel pair
`timescale 1ns/10ps
`include "sscc_params.svh"
module sscc_pair #(
  parameter int HALF_PERIODS = `SSCC_CONV_CYC_X2
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic start_rise,
  input  wire logic start_fall,
  input  wire logic tick,
  output logic      active,
  output logic      done,
  output logic      hold,
  output logic      pwr_down
);
  sscc_pkg::sscc_pair_state_t state_reg;
  logic [5:0]                 cnt_reg;
  logic                       last;

  assign last   = cnt_reg == 6'(HALF_PERIODS - 1);
  assign active = state_reg != sscc_pkg::PAIR_IDLE;

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= sscc_pkg::PAIR_IDLE;
    end else begin
      unique case (state_reg)
        sscc_pkg::PAIR_IDLE: begin
          if (start_rise) state_reg <= sscc_pkg::PAIR_WAIT;
        end
        sscc_pkg::PAIR_WAIT: begin
          if (start_fall) state_reg <= sscc_pkg::PAIR_IDLE;
          else if (tick) state_reg <= sscc_pkg::PAIR_CONV;
        end
        sscc_pkg::PAIR_CONV: begin
          if (start_fall) state_reg <= sscc_pkg::PAIR_IDLE;
          else if (tick && last) state_reg <= sscc_pkg::PAIR_IDLE;
        end
        default: state_reg <= sscc_pkg::PAIR_IDLE;
      endcase
    end
  end

  // Half periods, so 18.5 cycles ends on the right edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt_reg <= 6'h00;
    else if (state_reg != sscc_pkg::PAIR_CONV) cnt_reg <= 6'h00;
    else if (tick) cnt_reg <= cnt_reg + 6'h01;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) done <= 1'b0;
    else done <= state_reg == sscc_pkg::PAIR_CONV && tick && last &&
                 !start_fall;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) hold <= 1'b0;
    else if (start_rise) hold <= 1'b1;
    else if (start_fall || done) hold <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) pwr_down <= 1'b0;
    else if (start_rise) pwr_down <= 1'b0;
    else if (start_fall && active) pwr_down <= 1'b1;
  end
endmodule // sscc_pair

// File: sscc_dev.sv
// Device end: control word, conversion sequencing and busy output
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`include "sscc_params.svh"
module sscc_dev #(
  parameter int INT_HALF_CYC = `SSCC_INT_HALF_CYC,
  parameter int PAIRS        = 3
) (
  input  wire logic   SYS_CLK,
  input  wire logic   RST_N,
  sscc_if.dev         LNK,
  output logic        SW_MODE,
  output logic        SPAN_4X,
  output logic        REF_RANGE_3V,
  output logic [9:0]  DAC_CODE,
  output logic        REF_PD,
  output logic        BUF_PD,
  output logic        EXT_CLK_SEL,
  output logic [2:0]  PAIR_HOLD,
  output logic [2:0]  PAIR_PD,
  output logic [2:0]  PAIR_DONE
);
  logic [PAIRS-1:0] start_m_reg;
  logic [PAIRS-1:0] start_s_reg;
  logic             cfg_m_reg;
  logic             cfg_s_reg;
  logic             rng_m_reg;
  logic             rng_s_reg;
  logic             external_conversion_clock_m_reg;
  logic             external_conversion_clock_s_reg;
  logic             external_conversion_clock_d_reg;
  logic [31:0]      cw_reg;
  logic [PAIRS-1:0] eff_start;
  logic [PAIRS-1:0] eff_prev_reg;
  logic [PAIRS-1:0] rise;
  logic [PAIRS-1:0] fall;
  logic [7:0]       int_cnt_reg;
  logic             int_tick;
  logic             ext_tick;
  logic             tick;
  logic             sw;
  logic             seq;
  logic             pol;
  logic             ext_sel;
  logic [PAIRS-1:0] active;
  logic [PAIRS-1:0] done;
  logic [PAIRS-1:0] hold;
  logic [PAIRS-1:0] pd;
  logic             busy_reg;
  logic             busy_next;
  logic             busy_pin_reg;
  logic             span_lat_reg;

  ////////////////////////////////////////////////////////////////////
  // Pins come from another party; two stages before any use, except cw_wr and cw_data
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      start_m_reg <= '0;
      start_s_reg <= '0;
      cfg_m_reg   <= 1'b0;
      cfg_s_reg   <= 1'b0;
      rng_m_reg   <= 1'b0;
      rng_s_reg   <= 1'b0;
    end else begin
      start_m_reg <= LNK.start;
      start_s_reg <= start_m_reg;
      cfg_m_reg   <= LNK.cfg_src;
      cfg_s_reg   <= cfg_m_reg;
      rng_m_reg   <= LNK.range_pin;
      rng_s_reg   <= rng_m_reg;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      external_conversion_clock_m_reg <= 1'b0;
      external_conversion_clock_s_reg <= 1'b0;
      external_conversion_clock_d_reg <= 1'b0;
    end else begin
      external_conversion_clock_m_reg <= LNK.ext_clk;
      external_conversion_clock_s_reg <= external_conversion_clock_m_reg;
      external_conversion_clock_d_reg <= external_conversion_clock_s_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Control word; writes outside software mode are dropped
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) cw_reg <= `SSCC_CW_RESET;
    else if (LNK.cw_wr && cfg_s_reg) cw_reg <= LNK.cw_data;
  end

  assign sw      = cfg_s_reg;
  assign seq     = cw_reg[`SSCC_CW_SEQ];
  assign pol     = cw_reg[`SSCC_CW_POLARITY];
  assign ext_sel = sw && cw_reg[`SSCC_CW_CLK_SEL];

  ////////////////////////////////////////////////////////////////////
  // Start edges
  always_comb begin
    if (sw && !seq) eff_start = {PAIRS{start_s_reg[0]}};
    else eff_start = start_s_reg;
  end

  assign rise = eff_start & ~eff_prev_reg;
  assign fall = ~eff_start & eff_prev_reg;

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) eff_prev_reg <= '0;
    else eff_prev_reg <= eff_start;
  end

  ////////////////////////////////////////////////////////////////////
  // Conversion clock; every edge of either source is one tick
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) int_cnt_reg <= 8'h00;
    else if (int_tick) int_cnt_reg <= 8'h00;
    else int_cnt_reg <= int_cnt_reg + 8'h01;
  end

  assign int_tick = int_cnt_reg == 8'(INT_HALF_CYC - 1);
  // External clock may stop low between conversions; no tick then
  assign ext_tick = external_conversion_clock_s_reg ^ external_conversion_clock_d_reg;
  assign tick     = ext_sel ? ext_tick : int_tick;

  genvar g;
  generate
    for (g = 0; g < PAIRS; g++) begin : g_pair
      sscc_pair #(
        .HALF_PERIODS (`SSCC_CONV_CYC_X2)
      ) u_pair (
        .clk        (SYS_CLK),
        .rst_n      (RST_N),
        .start_rise (rise[g]),
        .start_fall (fall[g]),
        .tick       (tick),
        .active     (active[g]),
        .done       (done[g]),
        .hold       (hold[g]),
        .pwr_down   (pd[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Busy
  always_comb begin
    if (|rise) busy_next = 1'b1;
    else if (|done && seq) busy_next = 1'b0;
    else busy_next = |active;
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) busy_reg <= 1'b0;
    else busy_reg <= busy_next;
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) busy_pin_reg <= 1'b0;
    else busy_pin_reg <= busy_next ^ pol;
  end

  assign LNK.busy_int = busy_pin_reg;

  // Inverted polarity: the pin is simply tracked
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) span_lat_reg <= 1'b0;
    else if (!pol && busy_reg && !busy_next) span_lat_reg <= rng_s_reg;
    else if (pol) span_lat_reg <= rng_s_reg;
  end

  ////////////////////////////////////////////////////////////////////
  // Registered user-side outputs
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      SW_MODE      <= 1'b0;
      SPAN_4X      <= 1'b0;
      REF_RANGE_3V <= 1'b0;
      DAC_CODE     <= 10'h3FF;
      REF_PD       <= 1'b1;
      BUF_PD       <= 1'b0;
      EXT_CLK_SEL  <= 1'b0;
    end else begin
      SW_MODE      <= sw;
      SPAN_4X      <= sw ? cw_reg[`SSCC_CW_SPAN] : span_lat_reg;
      REF_RANGE_3V <= cw_reg[`SSCC_CW_REF_RANGE];
      DAC_CODE     <= cw_reg[`SSCC_CW_DAC_MSB:0];
      REF_PD       <= !cw_reg[`SSCC_CW_REF_EN];
      BUF_PD       <= cw_reg[`SSCC_CW_BUF_PD];
      EXT_CLK_SEL  <= ext_sel;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PAIR_HOLD <= 3'h0;
      PAIR_PD   <= 3'h0;
      PAIR_DONE <= 3'h0;
    end else begin
      PAIR_HOLD <= hold;
      PAIR_PD   <= pd;
      PAIR_DONE <= done;
    end
  end
endmodule // sscc_dev

// File: sscc_host.sv
// Host end: APB registers driving starts, config pins and clock
`timescale 1ns/10ps
`include "sscc_params.svh"
module sscc_host #(
  parameter int EXTERNAL_CONVERSION_CLOCK_HALF_CYC = `SSCC_EXTERNAL_CONVERSION_CLOCK_HALF_CYC
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  sscc_if.host             LNK,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR
);
  logic [2:0]  ctrl_reg;
  logic [2:0]  start_reg;
  logic [31:0] cw_reg;
  logic        cw_wr_reg;
  logic [7:0]  done_cnt_reg;
  logic        busy_m_reg;
  logic        busy_s_reg;
  logic        busy_d_reg;
  logic        busy_fell;
  logic        external_conversion_clock_reg;
  logic [7:0]  xdiv_reg;
  logic        setup;
  logic        wr_acc;
  logic [31:0] rd_val;
  logic        mapped;
  logic        pol_reg;
  logic        seq_reg;

  function automatic logic is_ofs(input logic [11:0] a,
                                  input logic [11:0] o);
    return a == o;
  endfunction

  assign setup  = PSEL && !PENABLE;
  assign wr_acc = PSEL && PENABLE && PREADY && PWRITE;
  assign mapped = is_ofs(PADDR, `SSCC_OFS_CTRL) ||
                  is_ofs(PADDR, `SSCC_OFS_START) ||
                  is_ofs(PADDR, `SSCC_OFS_CW) ||
                  is_ofs(PADDR, `SSCC_OFS_STATUS);

  ////////////////////////////////////////////////////////////////////
  // Busy pin, normalised by the polarity written to the device
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      busy_m_reg <= 1'b0;
      busy_s_reg <= 1'b0;
      busy_d_reg <= 1'b0;
    end else begin
      busy_m_reg <= LNK.busy_int;
      busy_s_reg <= busy_m_reg ^ pol_reg;
      busy_d_reg <= busy_s_reg;
    end
  end

  assign busy_fell = busy_d_reg && !busy_s_reg;

  ////////////////////////////////////////////////////////////////////
  // APB: no wait state, read data captured in the setup cycle, write data in the access cycle
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else begin
      PREADY  <= setup;
      PSLVERR <= setup && !mapped;
      PRDATA  <= (setup && !PWRITE) ? rd_val : 32'h0000_0000;
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    if (is_ofs(PADDR, `SSCC_OFS_CTRL)) rd_val[2:0] = ctrl_reg;
    if (is_ofs(PADDR, `SSCC_OFS_START)) rd_val[2:0] = start_reg;
    if (is_ofs(PADDR, `SSCC_OFS_CW)) rd_val = cw_reg;
    if (is_ofs(PADDR, `SSCC_OFS_STATUS)) begin
      rd_val[0]    = busy_s_reg;
      rd_val[3:1]  = start_reg;
      rd_val[15:8] = done_cnt_reg;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) ctrl_reg <= 3'h0;
    else if (wr_acc && is_ofs(PADDR, `SSCC_OFS_CTRL))
      ctrl_reg <= PWDATA[2:0];
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cw_reg    <= `SSCC_CW_RESET;
      cw_wr_reg <= 1'b0;
    end else begin
      cw_wr_reg <= wr_acc && is_ofs(PADDR, `SSCC_OFS_CW);
      if (wr_acc && is_ofs(PADDR, `SSCC_OFS_CW)) cw_reg <= PWDATA;
    end
  end

  // Device drops words in hardware mode, so shadow only what it takes
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pol_reg <= 1'b0;
      seq_reg <= 1'b0;
    end else if (wr_acc && is_ofs(PADDR, `SSCC_OFS_CW) && ctrl_reg[0]) begin
      pol_reg <= PWDATA[`SSCC_CW_POLARITY];
      seq_reg <= PWDATA[`SSCC_CW_SEQ];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Starts: set ignored on a high pair, held until busy falls when not sequential
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      start_reg <= 3'h0;
    end else if (wr_acc && is_ofs(PADDR, `SSCC_OFS_START)) begin
      start_reg <= (start_reg | PWDATA[2:0]) & ~PWDATA[6:4];
    end else if (busy_fell && !seq_reg) begin
      start_reg <= 3'h0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) done_cnt_reg <= 8'h00;
    else if (busy_fell) done_cnt_reg <= done_cnt_reg + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////
  // External clock runs only while a start is raised
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      xdiv_reg <= 8'h00;
      external_conversion_clock_reg <= 1'b0;
    end else if (!(ctrl_reg[2] && |start_reg)) begin
      xdiv_reg <= 8'h00;
      external_conversion_clock_reg <= 1'b0;
    end else if (xdiv_reg == 8'(EXTERNAL_CONVERSION_CLOCK_HALF_CYC - 1)) begin
      xdiv_reg <= 8'h00;
      external_conversion_clock_reg <= !external_conversion_clock_reg;
    end else begin
      xdiv_reg <= xdiv_reg + 8'h01;
    end
  end

  assign LNK.start     = start_reg;
  assign LNK.cfg_src   = ctrl_reg[0];
  assign LNK.range_pin = ctrl_reg[1];
  assign LNK.ext_clk   = external_conversion_clock_reg;
  assign LNK.cw_wr     = cw_wr_reg;
  assign LNK.cw_data   = cw_reg;
endmodule // sscc_host

// File: sscc_monitor.sv
// Link assertions between the converter device and its host end
`timescale 1ns/10ps
`include "sscc_params.svh"
module sscc_monitor #(
  parameter int INT_HALF_CYC = `SSCC_INT_HALF_CYC
) (
  input wire logic        SYS_CLK,
  input wire logic        RST_N,
  input wire logic [2:0]  start,
  input wire logic        cfg_src,
  input wire logic        range_pin,
  input wire logic        ext_clk,
  input wire logic        busy_int,
  input wire logic        cw_wr,
  input wire logic [31:0] cw_data
);
  // Lenient floor: first tick may land up to one half period late
  localparam int MIN_CONV = (`SSCC_CONV_CYC_X2 - 1) * INT_HALF_CYC;
  logic       pol_reg;
  logic       seen_reg;
  logic       cw_seen_reg;
  logic [2:0] start_q_reg;
  logic [9:0] hi_cnt_reg;
  logic [9:0] since_reg;
  logic       busy_n;
  logic       seq;
  assign busy_n = busy_int ^ pol_reg;
  assign seq    = cw_data[`SSCC_CW_SEQ];
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////////////////////////////////////////
  // Device only takes a control word in software mode
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) pol_reg <= 1'b0;
    else if (cw_wr && cfg_src) pol_reg <= cw_data[`SSCC_CW_POLARITY];
  end
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) seen_reg <= 1'b0;
    else if (|start) seen_reg <= 1'b1;
  end
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) cw_seen_reg <= 1'b0;
    else if (cw_wr) cw_seen_reg <= 1'b1;
  end
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) hi_cnt_reg <= 10'h000;
    else if (!busy_n) hi_cnt_reg <= 10'h000;
    else if (hi_cnt_reg != 10'h3FF) hi_cnt_reg <= hi_cnt_reg + 10'h001;
  end
  // Cycles since the latest start rise on any pair
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      start_q_reg <= 3'b000;
      since_reg   <= 10'h3FF;
    end else begin
      start_q_reg <= start;
      if (|(start & ~start_q_reg)) since_reg <= 10'h000;
      else if (since_reg != 10'h3FF) since_reg <= since_reg + 10'h001;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence start_a_rise;
    $rose(start[0]);
  endsequence
  sequence busy_fall;
    $fell(busy_n);
  endsequence
  busy_rise_a: assert property (start_a_rise |-> ##[2:6] busy_n)
    else $error("busy did not follow a pair A start");
  busy_idle_a: assert property (!seen_reg |-> !busy_n)
    else $error("busy active before any start");
  conv_len_a: assert property (
    busy_fall ##0 (!seq && $past(start[0])) |->
      $past(hi_cnt_reg) >= 10'(MIN_CONV))
    else $error("conversion ended too early");
  ext_idle_a: assert property ((start == 3'b000)[*8] |-> !ext_clk)
    else $error("external clock runs while idle");
  cw_reset_a: assert property (
    !cw_seen_reg && !cw_wr |-> cw_data == `SSCC_CW_RESET)
    else $error("control word differs from reset value");
  busy_pol_a: assert property (
    cw_wr && cfg_src && $past(cfg_src, 3) && start == 3'b000
      |-> ##[1:3] busy_int == cw_data[`SSCC_CW_POLARITY])
    else $error("idle busy level ignores polarity");
  hw_ignore_a: assert property (
    cw_wr && !cfg_src && !$past(cfg_src, 3) && start == 3'b000
      |=> $stable(busy_int)[*3])
    else $error("control word taken in hardware mode");
  seq_gap_a: assert property (
    busy_fall ##0 (seq && since_reg < 10'(MIN_CONV)) |=> busy_n)
    else $error("sequential busy gap longer than one cycle");
endmodule // sscc_monitor

// File: testbench.sv
// Self-checking bench for the converter device and its host end
`timescale 1ns/10ps
`include "sscc_params.svh"
module testbench;
  localparam int IHC = `SSCC_INT_HALF_CYC;
  localparam int XHC = `SSCC_EXTERNAL_CONVERSION_CLOCK_HALF_CYC;
  localparam int HP  = `SSCC_CONV_CYC_X2;
  logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        sw_mode, span_4x, ref_range_3v, ref_pd, buf_pd, ext_sel;
  logic [9:0]  dac_code;
  logic [2:0]  pair_hold, pair_pd, pair_done;
  logic [15:0] cfg;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          t0, n;
  assign cfg = {sw_mode, span_4x, ref_range_3v, ref_pd, buf_pd, ext_sel,
                dac_code};
  sscc_if sscc_if_i ();
  sscc_host sscc_host_i (.SYS_CLK(sys_clk), .RST_N(rst_n),
    .LNK(sscc_if_i.host), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr));
  sscc_dev #(.INT_HALF_CYC(IHC)) sscc_dev_i (.SYS_CLK(sys_clk),
    .RST_N(rst_n), .LNK(sscc_if_i.dev), .SW_MODE(sw_mode),
    .SPAN_4X(span_4x), .REF_RANGE_3V(ref_range_3v), .DAC_CODE(dac_code),
    .REF_PD(ref_pd), .BUF_PD(buf_pd), .EXT_CLK_SEL(ext_sel),
    .PAIR_HOLD(pair_hold), .PAIR_PD(pair_pd), .PAIR_DONE(pair_done));
  sscc_monitor #(.INT_HALF_CYC(IHC)) sscc_monitor_i (.SYS_CLK(sys_clk),
    .RST_N(rst_n), .start(sscc_if_i.start), .cfg_src(sscc_if_i.cfg_src),
    .range_pin(sscc_if_i.range_pin), .ext_clk(sscc_if_i.ext_clk),
    .busy_int(sscc_if_i.busy_int), .cw_wr(sscc_if_i.cw_wr),
    .cw_data(sscc_if_i.cw_data));
  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Holds the request until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(q, exp);
  endtask
  task automatic go(input logic [31:0] d);
    wr(`SSCC_OFS_START, d);
    t0 = cyc;
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge sys_clk);
  endtask
  // Done is a one-cycle pulse, so every edge is looked at
  task automatic wdone(input int b);
    do @(posedge sys_clk); while (pair_done[b] !== 1'b1);
    n = cyc - t0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // Non-blocking, so tasks read the count race-free at an edge
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    rst_n   = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    wt(2);
    chk(32'(cfg), 32'h0000_13FF);
    rd(`SSCC_OFS_CW, 32'h0000_03FF);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk(32'({e, q == 32'h0000_0000}), 32'h0000_0003);
    $display("test reset done");
    go(32'h0000_0003);
    wt(6);
    chk(32'({pair_hold, sscc_if_i.busy_int}), 32'h0000_0007);
    wr(`SSCC_OFS_CTRL, 32'h0000_0002);
    wt(8);
    chk(32'(cfg), 32'h0000_13FF);
    wdone(0);
    // Two sync stages, detect, done, output stage, then 1..IHC wait
    chk(32'(n >= HP * IHC + 5 && n <= (HP + 1) * IHC + 6),
        32'h0000_0001);
    wt(4);
    chk(32'(cfg), 32'h0000_53FF);
    rd(`SSCC_OFS_STATUS, 32'h0000_0100);
    chk(32'(pair_pd), 32'h0000_0000);
    $display("test hardware conversion done");
    go(32'h0000_0001);
    wt(12);
    wr(`SSCC_OFS_START, 32'h0000_0010);
    wt(8);
    chk(32'(pair_pd), 32'h0000_0001);
    wr(`SSCC_OFS_CW, 32'h0014_0000);
    wt(6);
    chk(32'(cfg), 32'h0000_53FF);
    $display("test abort and hardware write done");
    wr(`SSCC_OFS_CTRL, 32'h0000_0001);
    wt(4);
    wr(`SSCC_OFS_CW, 32'h0404_30CC);
    wt(4);
    chk(32'(cfg), 32'h0000_E8CC);
    wr(`SSCC_OFS_START, 32'h0000_0002);
    wt(12);
    chk(32'({pair_hold, sscc_if_i.busy_int}), 32'h0000_0000);
    wr(`SSCC_OFS_START, 32'h0000_0020);
    go(32'h0000_0001);
    wt(6);
    chk(32'({pair_hold, pair_pd}), 32'h0000_0038);
    wdone(0);
    $display("test software mode done");
    wt(4);
    wr(`SSCC_OFS_CW, 32'h0414_30CC);
    wt(4);
    chk(32'(sscc_if_i.busy_int), 32'h0000_0001);
    go(32'h0000_0001);
    wt(6);
    chk(32'(sscc_if_i.busy_int), 32'h0000_0000);
    wdone(0);
    wt(4);
    chk(32'(sscc_if_i.busy_int), 32'h0000_0001);
    $display("test polarity done");
    wr(`SSCC_OFS_CTRL, 32'h0000_0005);
    wr(`SSCC_OFS_CW, 32'h0404_38CC);
    wt(4);
    chk(32'(cfg), 32'h0000_ECCC);
    go(32'h0000_0001);
    wdone(0);
    // Clock starts with the start; its first synced edge ends the wait
    chk(32'(n >= HP * XHC + 11 && n <= HP * XHC + 13),
        32'h0000_0001);
    $display("test external clock done");
    wt(4);
    wr(`SSCC_OFS_CTRL, 32'h0000_0001);
    wr(`SSCC_OFS_CW, 32'h0484_30CC);
    wt(4);
    go(32'h0000_0001);
    wt(40);
    wr(`SSCC_OFS_START, 32'h0000_0002);
    wdone(0);
    chk(32'(sscc_if_i.busy_int), 32'h0000_0000);
    wt(3);
    chk(32'(sscc_if_i.busy_int), 32'h0000_0001);
    wdone(1);
    wr(`SSCC_OFS_START, 32'h0000_0070);
    $display("test sequential mode done");
    wrap_up();
  end
endmodule // testbench
